// >>> hw/eq_coef_mem.sv
// coefficient store for both channel tap sets, registered read ports
`timescale 1ns/1ps
module eq_coef_mem #(
  parameter int DEPTH = 22,
  parameter int AW    = 5
) (
  input  wire logic          clock_i,
  input  wire logic          rst_i,
  input  wire logic          ce_i,
  input  wire logic          wr_en_i,
  input  wire logic [AW-1:0] wr_addr_i,
  input  wire logic [1:0]    wr_be_i,
  input  wire logic [7:0]    wr_data_i,
  input  wire logic [AW-1:0] rd0_addr_i,
  input  wire logic [AW-1:0] rd1_addr_i,
  input  wire logic [AW-1:0] rd2_addr_i,
  output logic      [15:0]   rd0_data_o,
  output logic      [15:0]   rd1_data_o,
  output logic      [15:0]   rd2_data_o
);
  typedef struct packed {
    logic [DEPTH-1:0][15:0] mem;
    logic [15:0]            rd0;
    logic [15:0]            rd1;
    logic [15:0]            rd2;
  } mem_state_t;

  mem_state_t st;
  mem_state_t next_st;

  always_comb begin
    next_st = st;
    // read before write: a same-cycle read returns the old word
    next_st.rd0 = st.mem[rd0_addr_i];
    next_st.rd1 = st.mem[rd1_addr_i];
    next_st.rd2 = st.mem[rd2_addr_i];
    if (wr_en_i && (int'(wr_addr_i) < DEPTH)) begin
      if (wr_be_i[0]) begin
        next_st.mem[wr_addr_i][7:0] = wr_data_i;
      end
      if (wr_be_i[1]) begin
        next_st.mem[wr_addr_i][15:8] = wr_data_i;
      end
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      st.mem <= {DEPTH{eq_pkg::COEF_RST}};
      st.rd0 <= 16'h0000;
      st.rd1 <= 16'h0000;
      st.rd2 <= 16'h0000;
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  assign rd0_data_o = st.rd0;
  assign rd1_data_o = st.rd1;
  assign rd2_data_o = st.rd2;
endmodule

// >>> hw/eq_pkg.sv
// constants and register map of the equaliser fir configuration block
package eq_pkg;
  localparam int          ADDR_W         = 15;
  localparam int          DATA_W         = 8;
  localparam int          COEF_W         = 16;
  localparam logic [14:0] FIR_CONFIG_OFS = 15'h0400;
  localparam logic [14:0] COEF_A_BASE    = 15'h0418;
  localparam logic [14:0] COEF_B_BASE    = 15'h0430;
  localparam logic [14:0] FINE_GAIN_OFS  = 15'h0357;
  localparam logic [7:0]  FIR_CONFIG_RST = 8'h00;
  localparam logic [7:0]  FINE_GAIN_RST  = 8'h00;
  localparam logic [15:0] COEF_RST       = 16'h0000;
  localparam int          SHARE_BIT      = 6;
  localparam int          MERGE_BIT      = 5;
  localparam int          SCW_LSB        = 2;
  localparam int          SCW_W          = 3;
  localparam int          MODE_LSB       = 0;
  localparam int          MODE_W         = 2;
  localparam logic [2:0]  SCW_MAX        = 3'h6;
  localparam logic [1:0]  MODE_OFF       = 2'h0;
  localparam logic [1:0]  MODE_ON        = 2'h2;
  localparam int          GAIN_W         = 5;
  localparam int          SCW_BASE_EXP   = -16;
endpackage

// >>> hw/fir_equalizer_config.sv
// equaliser fir configuration registers, tap lookup and sample routing
`timescale 1ns/1ps
module fir_equalizer_config #(
  parameter int TAPS      = 11,
  parameter int SAMPLE_W  = 8,
  parameter int COEF_OUT_W = 22
) (
  input  wire logic                  clock_i,
  input  wire logic                  rst_i,
  input  wire logic                  ce_i,
  input  wire logic [14:0]           reg_addr_i,
  input  wire logic [7:0]            reg_wdata_i,
  input  wire logic                  reg_we_i,
  input  wire logic                  reg_re_i,
  output logic      [7:0]            reg_rdata_o,
  output logic                       reg_rvalid_o,
  input  wire logic                  coef_req_i,
  input  wire logic [7:0]            coef_tap_i,
  output logic      [COEF_OUT_W-1:0] coef_a_o,
  output logic      [COEF_OUT_W-1:0] coef_b_o,
  output logic                       coef_valid_o,
  input  wire logic                  in_valid_i,
  input  wire logic [SAMPLE_W-1:0]   in_a_i,
  input  wire logic [SAMPLE_W-1:0]   in_b_i,
  output logic                       byp_valid_o,
  output logic      [SAMPLE_W-1:0]   byp_a_o,
  output logic      [SAMPLE_W-1:0]   byp_b_o,
  output logic                       eng_valid_o,
  output logic                       eng_merged_o,
  output logic      [SAMPLE_W-1:0]   eng_first_o,
  output logic      [SAMPLE_W-1:0]   eng_second_o,
  output logic                       filter_enable_o,
  output logic      [4:0]            fine_gain_b_bank1_o
);
  localparam int DEPTH  = 2 * TAPS;
  localparam int AW     = $clog2(DEPTH);
  localparam int CENTER = (TAPS - 1) / 2;

  typedef struct packed {
    logic [7:0]            fir_config;
    logic [7:0]            fine_gain;
    logic                  fen;
    logic                  rd_pend;
    logic                  rd_coef;
    logic                  rd_hi;
    logic [7:0]            rd_hold;
    logic [7:0]            rdata;
    logic                  rvalid;
    logic                  cf_pend;
    logic                  cf_center;
    logic [COEF_OUT_W-1:0] coef_a;
    logic [COEF_OUT_W-1:0] coef_b;
    logic                  coef_valid;
    logic                  byp_valid;
    logic [SAMPLE_W-1:0]   byp_a;
    logic [SAMPLE_W-1:0]   byp_b;
    logic                  eng_valid;
    logic                  eng_merged;
    logic [SAMPLE_W-1:0]   eng_first;
    logic [SAMPLE_W-1:0]   eng_second;
  } state_t;

  state_t st;
  state_t next_st;

  function automatic logic coef_hit(input logic [14:0] a,
                                    input logic [14:0] base);
    coef_hit = (a >= base) && (a < base + 15'(DEPTH));
  endfunction

  function automatic logic [AW-1:0] coef_word(input logic [14:0] a,
                                              input logic [14:0] base,
                                              input logic        bank_b);
    logic [14:0] off;
    off = a - base;
    coef_word = AW'(off >> 1) + (bank_b ? AW'(TAPS) : AW'(0));
  endfunction

  // weight is kept in units of 2^-16, so a side tap shifts by the weight, held at SCW_MAX (6) for 7
  function automatic logic [COEF_OUT_W-1:0] scale(input logic [15:0] c,
                                                  input logic [2:0]  scw,
                                                  input logic        ctr);
    logic [2:0]                   s;
    logic signed [COEF_OUT_W-1:0] x;
    s = (scw > eq_pkg::SCW_MAX) ? eq_pkg::SCW_MAX : scw;
    x = COEF_OUT_W'($signed(c));
    scale = ctr ? x : (x <<< s);
  endfunction

  logic [2:0]    scw;
  logic [1:0]    mode;
  logic          enabled;
  logic          a_hit;
  logic          b_hit;
  logic [AW-1:0] reg_word;
  logic [AW-1:0] tap_a_word;
  logic [AW-1:0] tap_b_word;
  logic          tap_ok;
  logic [AW-1:0] tap_idx;
  logic [15:0]   rd_word;
  logic [15:0]   tap_a_data;
  logic [15:0]   tap_b_data;

  assign scw  = st.fir_config[eq_pkg::SCW_LSB +: eq_pkg::SCW_W];
  assign mode = st.fir_config[eq_pkg::MODE_LSB +: eq_pkg::MODE_W];
  // reserved codes behave as disabled
  assign enabled = (mode == eq_pkg::MODE_ON);
  assign a_hit = coef_hit(reg_addr_i, eq_pkg::COEF_A_BASE);
  assign b_hit = coef_hit(reg_addr_i, eq_pkg::COEF_B_BASE);
  assign reg_word = b_hit ? coef_word(reg_addr_i, eq_pkg::COEF_B_BASE, 1'b1)
                  : a_hit ? coef_word(reg_addr_i, eq_pkg::COEF_A_BASE, 1'b0)
                  : AW'(0);
  assign tap_ok  = (int'(coef_tap_i) < TAPS);
  // park an out-of-range lookup on word 0 so the store is never indexed
  // past its end; that answer is dropped anyway
  assign tap_idx = tap_ok ? AW'(coef_tap_i) : AW'(0);
  assign tap_a_word = tap_idx;
  assign tap_b_word = st.fir_config[eq_pkg::SHARE_BIT]
                    ? tap_idx
                    : tap_idx + AW'(TAPS);

  // port 0 serves the register bus, ports 1 and 2 the two channels
  eq_coef_mem #(
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_mem (
    .clock_i    (clock_i),
    .rst_i      (rst_i),
    .ce_i       (ce_i),
    .wr_en_i    (reg_we_i && (a_hit || b_hit)),
    .wr_addr_i  (reg_word),
    .wr_be_i    ({reg_addr_i[0], ~reg_addr_i[0]}),
    .wr_data_i  (reg_wdata_i),
    .rd0_addr_i (reg_word),
    .rd1_addr_i (tap_a_word),
    .rd2_addr_i (tap_b_word),
    .rd0_data_o (rd_word),
    .rd1_data_o (tap_a_data),
    .rd2_data_o (tap_b_data)
  );

  always_comb begin
    next_st = st;
    // register writes; no interlock against a running link, software
    // is trusted to change these only with the link off
    if (reg_we_i) begin
      if (reg_addr_i == eq_pkg::FIR_CONFIG_OFS) begin
        next_st.fir_config = reg_wdata_i;
      end
      if (reg_addr_i == eq_pkg::FINE_GAIN_OFS) begin
        next_st.fine_gain = reg_wdata_i;
      end
    end
    // the enable pin comes from its own flop, kept equal to the mode field being MODE_ON
    next_st.fen = (next_st.fir_config[eq_pkg::MODE_LSB +: eq_pkg::MODE_W]
                   == eq_pkg::MODE_ON);
    // reads answer two cycles after the request, mapped or not
    next_st.rd_pend = reg_re_i;
    next_st.rd_coef = a_hit || b_hit;
    next_st.rd_hi   = reg_addr_i[0];
    if (reg_addr_i == eq_pkg::FIR_CONFIG_OFS) begin
      next_st.rd_hold = st.fir_config;
    end else if (reg_addr_i == eq_pkg::FINE_GAIN_OFS) begin
      next_st.rd_hold = st.fine_gain;
    end else begin
      next_st.rd_hold = 8'h00;
    end
    next_st.rvalid = st.rd_pend;
    if (st.rd_pend) begin
      if (st.rd_coef) begin
        next_st.rdata = st.rd_hi ? rd_word[15:8] : rd_word[7:0];
      end else begin
        next_st.rdata = st.rd_hold;
      end
    end
    // tap lookup for the filter arithmetic
    next_st.cf_pend    = coef_req_i && tap_ok;
    next_st.cf_center  = (int'(coef_tap_i) == CENTER);
    next_st.coef_valid = st.cf_pend;
    if (st.cf_pend) begin
      next_st.coef_a = scale(tap_a_data, scw, st.cf_center);
      next_st.coef_b = scale(tap_b_data, scw, st.cf_center);
    end
    // sample routing
    next_st.byp_valid = in_valid_i && !enabled;
    next_st.eng_valid = in_valid_i && enabled;
    next_st.eng_merged = st.fir_config[eq_pkg::MERGE_BIT];
    if (in_valid_i && !enabled) begin
      next_st.byp_a = in_a_i;
      next_st.byp_b = in_b_i;
    end
    if (in_valid_i && enabled) begin
      // merged: a is the older sample, b the next one of the same stream
      next_st.eng_first  = in_a_i;
      next_st.eng_second = in_b_i;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      st            <= '0;
      st.fir_config <= eq_pkg::FIR_CONFIG_RST;
      st.fine_gain  <= eq_pkg::FINE_GAIN_RST;
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  assign reg_rdata_o         = st.rdata;
  assign reg_rvalid_o        = st.rvalid;
  assign coef_a_o            = st.coef_a;
  assign coef_b_o            = st.coef_b;
  assign coef_valid_o        = st.coef_valid;
  assign byp_valid_o         = st.byp_valid;
  assign byp_a_o             = st.byp_a;
  assign byp_b_o             = st.byp_b;
  assign eng_valid_o         = st.eng_valid;
  assign eng_merged_o        = st.eng_merged;
  assign eng_first_o         = st.eng_first;
  assign eng_second_o        = st.eng_second;
  assign filter_enable_o     = st.fen;
  assign fine_gain_b_bank1_o = st.fine_gain[4:0];
endmodule

// >>> tb/fir_equalizer_config_chk.sv
// assertion checker for the equaliser fir configuration block
`timescale 1ns/1ps
module fir_equalizer_config_chk #(
  parameter int TAPS     = 11,
  parameter int SAMPLE_W = 8
) (
  input wire logic                clock_i,
  input wire logic                rst_i,
  input wire logic                ce_i,
  input wire logic                reg_we_i,
  input wire logic                reg_re_i,
  input wire logic                reg_rvalid_o,
  input wire logic                coef_req_i,
  input wire logic [7:0]          coef_tap_i,
  input wire logic                coef_valid_o,
  input wire logic                in_valid_i,
  input wire logic [SAMPLE_W-1:0] in_a_i,
  input wire logic                byp_valid_o,
  input wire logic [SAMPLE_W-1:0] byp_a_o,
  input wire logic                eng_valid_o,
  input wire logic                eng_merged_o,
  input wire logic [SAMPLE_W-1:0] eng_first_o,
  input wire logic                filter_enable_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  property p_rd_lat; reg_re_i && ce_i ##1 ce_i |=> reg_rvalid_o; endproperty
  a_rd_lat: assert property (p_rd_lat)
    else $error("read answer missing two cycles after request");
  property p_rd_cause; reg_rvalid_o |-> $past(reg_re_i, 2); endproperty
  a_rd_cause: assert property (p_rd_cause)
    else $error("read answer without request");
  property p_coef_lat;
    coef_req_i && ce_i && coef_tap_i < TAPS ##1 ce_i |=> coef_valid_o;
  endproperty
  a_coef_lat: assert property (p_coef_lat)
    else $error("tap lookup answer missing");
  property p_coef_cause; coef_valid_o |-> $past(coef_req_i, 2); endproperty
  a_coef_cause: assert property (p_coef_cause)
    else $error("tap answer without request");
  property p_byp;
    in_valid_i && ce_i && !filter_enable_o
      |=> byp_valid_o && !eng_valid_o && byp_a_o == $past(in_a_i);
  endproperty
  a_byp: assert property (p_byp)
    else $error("sample not passed through while filter off");
  property p_eng;
    in_valid_i && ce_i && filter_enable_o |=> eng_valid_o && !byp_valid_o
      && (!eng_merged_o || eng_first_o == $past(in_a_i));
  endproperty
  a_eng: assert property (p_eng)
    else $error("sample not routed to filter engine in order");
  property p_out_cause;
    byp_valid_o || eng_valid_o |-> $past(in_valid_i);
  endproperty
  a_out_cause: assert property (p_out_cause)
    else $error("sample output without input");
  property p_fen; $changed(filter_enable_o) |-> $past(reg_we_i); endproperty
  a_fen: assert property (p_fen)
    else $error("filter enable changed without register write");
endmodule

bind fir_equalizer_config fir_equalizer_config_chk #(.TAPS(TAPS),
  .SAMPLE_W(SAMPLE_W)) u_chk (.clock_i, .rst_i, .ce_i, .reg_we_i,
  .reg_re_i, .reg_rvalid_o, .coef_req_i, .coef_tap_i, .coef_valid_o,
  .in_valid_i, .in_a_i, .byp_valid_o, .byp_a_o, .eng_valid_o,
  .eng_merged_o, .eng_first_o, .filter_enable_o);

// >>> tb/tb_fir_equalizer_config.sv
// self-checking bench for the equaliser fir configuration block
`timescale 1ns/1ps
module tb_fir_equalizer_config;
  logic        clock_i, rst_i, ce_i, reg_we_i, reg_re_i, coef_req_i;
  logic        in_valid_i, reg_rvalid_o, coef_valid_o, byp_valid_o;
  logic        eng_valid_o, eng_merged_o, filter_enable_o, en;
  logic [14:0] reg_addr_i;
  logic [7:0]  reg_wdata_i, reg_rdata_o, coef_tap_i, in_a_i, in_b_i;
  logic [7:0]  byp_a_o, byp_b_o, eng_first_o, eng_second_o;
  logic [21:0] coef_a_o, coef_b_o, ea, eb;
  logic [4:0]  fine_gain_b_bank1_o;
  int          fail_count, checked, s;
  fir_equalizer_config u_dut (.clock_i, .rst_i, .ce_i, .reg_addr_i,
    .reg_wdata_i, .reg_we_i, .reg_re_i, .reg_rdata_o, .reg_rvalid_o,
    .coef_req_i, .coef_tap_i, .coef_a_o, .coef_b_o, .coef_valid_o,
    .in_valid_i, .in_a_i, .in_b_i, .byp_valid_o, .byp_a_o, .byp_b_o,
    .eng_valid_o, .eng_merged_o, .eng_first_o, .eng_second_o,
    .filter_enable_o, .fine_gain_b_bank1_o);
  task automatic chk(input logic [21:0] got, input logic [21:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    @(negedge clock_i);
    reg_we_i    = 1'b1;
    reg_addr_i  = a;
    reg_wdata_i = d;
    @(negedge clock_i);
    reg_we_i = 1'b0;
  endtask
  // answer stands for one cycle, launched by the edge after the taking edge
  task automatic rd(input logic [14:0] a, input logic [7:0] e);
    @(negedge clock_i);
    reg_re_i   = 1'b1;
    reg_addr_i = a;
    @(negedge clock_i);
    reg_re_i = 1'b0;
    @(negedge clock_i);
    chk(22'(reg_rvalid_o), 22'h1);
    chk(22'(reg_rdata_o), 22'(e));
  endtask
  task automatic look(input logic [7:0] t, input logic v);
    @(negedge clock_i);
    coef_req_i = 1'b1;
    coef_tap_i = t;
    @(negedge clock_i);
    coef_req_i = 1'b0;
    @(negedge clock_i);
    chk(22'(coef_valid_o), 22'(v));
    if (v) begin
      chk(coef_a_o, ea);
      chk(coef_b_o, eb);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  initial begin
    #100000;
    fail_count++;
    tally_and_finish();
  end
  initial begin
    {rst_i, ce_i, reg_we_i, reg_re_i, coef_req_i, in_valid_i} = 6'h30;
    {reg_addr_i, reg_wdata_i, coef_tap_i, in_a_i, in_b_i} = '0;
    repeat (8) @(posedge clock_i);
    @(negedge clock_i);
    rst_i = 1'b0;
    rd(15'h0400, 8'h00);
    rd(15'h0357, 8'h00);
    wr(15'h07FF, 8'h5A);
    rd(15'h07FF, 8'h00);
    wr(15'h0357, 8'hFF);
    rd(15'h0357, 8'hFF);
    chk(22'(fine_gain_b_bank1_o), 22'h1F);
    for (int i = 0; i < 11; i++) begin
      wr(15'(16'h0418 + 2 * i), 8'(i + 1));
      wr(15'(16'h0430 + 2 * i), 8'(8'h40 + i));
      wr(15'(16'h0431 + 2 * i), 8'h01);
    end
    // side weight 7 is applied as 6
    for (int k = 0; k < 8; k++) begin
      wr(15'h0400, {1'b0, k[0], 1'b0, k[2:0], 2'h0});
      for (int t = 0; t <= 10; t += 5) begin
        s  = (t == 5) ? 0 : ((k > 6) ? 6 : k);
        ea = 22'(t + 1) << s;
        eb = (k[0] ? 22'(t + 1) : 22'(16'h0140 + t)) << s;
        look(8'(t), 1'b1);
      end
    end
    look(8'h0B, 1'b0);
    for (int k = 0; k < 8; k++) begin
      wr(15'h0400, {2'h0, k[2], 3'h0, k[1:0]});
      @(negedge clock_i);
      in_valid_i = 1'b1;
      in_a_i     = 8'(16 * k + 1);
      in_b_i     = ~in_a_i;
      @(negedge clock_i);
      in_valid_i = 1'b0;
      en         = (k[1:0] == 2'h2);
      chk(22'(filter_enable_o), 22'(en));
      chk(22'(eng_valid_o), 22'(en));
      chk(22'(byp_valid_o), 22'(!en));
      chk(22'(en ? eng_first_o : byp_a_o), 22'(in_a_i));
      chk(22'(en ? eng_second_o : byp_b_o), 22'(in_b_i));
      if (en) chk(22'(eng_merged_o), 22'(k[2]));
    end
    wr(15'h0400, 8'hA5);
    rd(15'h0400, 8'hA5);
    tally_and_finish();
  end
endmodule
